// ---- hw/addr_gen_pkg.sv ----
// package with constants, types and the functional notes of the addressing block
// Functional notes
// - direct mode takes the data address from one address byte of the instruction.
// - indirect mode addresses data through the selected first or second data pointer.
// - post-modify accesses at pointer value, then steps pointer by one afterward.
// - immediate operand is fetched from program memory right after the opcode.
// - short immediate puts 4-bit value in low nibble of the first data pointer only, clears its upper nibble.
// - table load reads program memory at high byte and accumulator, restores low byte.
// - program counter is high and low byte, 15 bits used, top bit unused.
// - short relative jump adds six-bit displacement, range -31 to +32.
// - absolute jump loads low 12 bits and keeps the upper three bits.
// - long absolute jump replaces all 15 program counter bits.
// - table jump loads fetched byte into low byte, upper byte unchanged.
// - any single data bit can be set, cleared or tested.
// - only the stack pointer (written at FD) is memory mapped; the two data pointers are not.
// - most single-byte instructions finish in one instruction cycle.
// - register window spans data addresses F0 to FF, holding pointers and stack; here only the stack pointer at FD is mapped in it.
// - vector jump fetches two adjacent program bytes into the program counter.
package addr_gen_pkg;
  localparam int PC_W = 15;
  localparam int DA_W = 8;
  localparam logic [7:0] REG_WIN_BASE = 8'hF0;
  localparam logic [7:0] PTR1_ADDR = 8'hFC;
  localparam logic [7:0] SP_ADDR = 8'hFD;
  localparam logic [7:0] PTR0_ADDR = 8'hFE;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h6F;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] NIB_CLR = 8'h0F;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_DIRECT = 4'h1, OP_IND = 4'h2, OP_IND_INC = 4'h3,
    OP_IND_DEC = 4'h4, OP_IMM = 4'h5, OP_IMM_SHORT = 4'h6, OP_TABLE_LOAD = 4'h7,
    OP_REL_JUMP = 4'h8, OP_ABS_JUMP = 4'h9, OP_LONG_JUMP = 4'hA, OP_TABLE_JUMP = 4'hB,
    OP_VECTOR_JUMP = 4'hC, OP_BIT_OP = 4'hD
  } op_mode_e;

  typedef enum logic [1:0] {BIT_SET = 2'h0, BIT_CLR = 2'h1, BIT_TEST = 2'h2} bit_op_e;

  typedef struct packed {
    logic valid;
    op_mode_e mode;
    logic ptr_sel;
    logic [7:0] addr_byte;
    logic [3:0] short_val;
    logic [5:0] rel_disp;
    logic [11:0] abs_target;
    logic [14:0] long_target;
    logic [2:0] bit_num;
    bit_op_e bit_op;
    logic [14:0] vector_addr;
  } instr_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [DA_W-1:0] addr;
    logic [7:0] wdata;
  } dmem_req_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_FETCH1 = 6'b000010, ST_FETCH2 = 6'b000100,
    ST_DATA = 6'b001000, ST_WRITE = 6'b010000, ST_DONE = 6'b100000
  } seq_state_e;
endpackage

// ---- hw/ptr_step.sv ----
// pointer update unit: short load and post step of one data pointer
`timescale 1ns/1ps
`default_nettype none
module ptr_step
  import addr_gen_pkg::*;
(
  input wire logic [7:0] cur,
  input wire logic load_short,
  input wire logic [3:0] short_val,
  input wire logic inc,
  input wire logic dec,
  output logic [7:0] nxt
);
  always_comb begin
    if (load_short) begin
      nxt = {4'h0, short_val} & NIB_CLR;
    end else if (inc) begin
      nxt = cur + BYTE_ONE;
    end else if (dec) begin
      nxt = cur - BYTE_ONE;
    end else begin
      nxt = cur;
    end
  end
endmodule // ptr_step
`default_nettype wire

// ---- hw/operand_and_jump_addressing.sv ----
// operand address generation and program counter update for the core
`timescale 1ns/1ps
`default_nettype none
module operand_and_jump_addressing
  import addr_gen_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire instr_s instr,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] pmem_rdata,
  input wire logic [7:0] dmem_rdata,
  output logic busy,
  output logic done,
  output logic [PC_W-1:0] pmem_addr,
  output logic pmem_rd,
  output dmem_req_s dmem_req,
  output logic [7:0] operand,
  output logic operand_valid,
  output logic acc_load,
  output logic [7:0] acc_out,
  output logic bit_result,
  output logic [PC_W-1:0] pc,
  output logic [7:0] ptr0,
  output logic [7:0] ptr1,
  output logic [7:0] stack_ptr
);
  seq_state_e state_reg;
  instr_s cur_reg;
  logic [7:0] hold_reg;
  logic [7:0] ptr0_next;
  logic [7:0] ptr1_next;
  logic [7:0] sel_ptr;
  logic [DA_W-1:0] ind_addr;
  logic step_now;
  logic short_now;
  logic [PC_W-1:0] rel_target;
  logic [PC_W-1:0] pc_inc;

  // pointer chosen by the instruction being accepted, not the one held from before
  assign sel_ptr = instr.ptr_sel ? ptr1 : ptr0;
  assign ind_addr = sel_ptr;
  assign pc_inc = pc + PC_ONE;
  // displacement field d gives distance d-31; zero-extended then offset
  assign rel_target = pc + {{(PC_W-6){1'b0}}, cur_reg.rel_disp} - 15'd31;
  assign step_now = (state_reg == ST_DONE);
  assign short_now = step_now && cur_reg.mode == OP_IMM_SHORT;

  ptr_step u_ptr0 (
    .cur(ptr0),
    .load_short(short_now && !cur_reg.ptr_sel),
    .short_val(cur_reg.short_val),
    .inc(step_now && !cur_reg.ptr_sel && cur_reg.mode == OP_IND_INC),
    .dec(step_now && !cur_reg.ptr_sel && cur_reg.mode == OP_IND_DEC),
    .nxt(ptr0_next)
  );
  ptr_step u_ptr1 (
    .cur(ptr1),
    .load_short(1'b0),
    .short_val(cur_reg.short_val),
    .inc(step_now && cur_reg.ptr_sel && cur_reg.mode == OP_IND_INC),
    .dec(step_now && cur_reg.ptr_sel && cur_reg.mode == OP_IND_DEC),
    .nxt(ptr1_next)
  );

  // sequencer: single-byte modes finish in one pass through done
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (instr.valid) begin
            cur_reg <= instr;
            case (instr.mode)
              OP_DIRECT, OP_IND, OP_IND_INC, OP_IND_DEC, OP_BIT_OP: state_reg <= ST_DATA;
              OP_IMM, OP_TABLE_LOAD, OP_TABLE_JUMP, OP_VECTOR_JUMP: state_reg <= ST_FETCH1;
              default: state_reg <= ST_DONE;
            endcase
          end
        end
        ST_FETCH1: state_reg <= (cur_reg.mode == OP_VECTOR_JUMP) ? ST_FETCH2 : ST_DONE;
        ST_FETCH2: state_reg <= ST_DONE;
        ST_DATA: begin
          if (cur_reg.mode == OP_BIT_OP && cur_reg.bit_op != BIT_TEST) begin
            state_reg <= ST_WRITE;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_WRITE: state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // program memory address for table, immediate and vector fetches
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pmem_addr <= PC_RST;
      pmem_rd <= 1'b0;
    end else if (state_reg == ST_IDLE && instr.valid) begin
      pmem_rd <= (instr.mode == OP_IMM || instr.mode == OP_TABLE_LOAD ||
                  instr.mode == OP_TABLE_JUMP || instr.mode == OP_VECTOR_JUMP);
      if (instr.mode == OP_IMM) begin
        pmem_addr <= pc_inc;
      end else if (instr.mode == OP_TABLE_LOAD || instr.mode == OP_TABLE_JUMP) begin
        pmem_addr <= {pc[14:8], acc_in};
      end else begin
        pmem_addr <= instr.vector_addr;
      end
    end else if (state_reg == ST_FETCH1 && cur_reg.mode == OP_VECTOR_JUMP) begin
      pmem_addr <= pmem_addr + PC_ONE;
      pmem_rd <= 1'b1;
    end else begin
      pmem_rd <= 1'b0;
    end
  end

  // data memory requests, including read-modify-write for bit operations
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dmem_req <= '0;
    end else if (state_reg == ST_IDLE && instr.valid) begin
      dmem_req.rd <= (instr.mode == OP_DIRECT || instr.mode == OP_IND ||
                      instr.mode == OP_IND_INC || instr.mode == OP_IND_DEC ||
                      instr.mode == OP_BIT_OP);
      dmem_req.wr <= 1'b0;
      if (instr.mode == OP_DIRECT || instr.mode == OP_BIT_OP) begin
        dmem_req.addr <= instr.addr_byte;
      end else begin
        dmem_req.addr <= ind_addr;
      end
    end else if (state_reg == ST_DATA && cur_reg.mode == OP_BIT_OP &&
                 cur_reg.bit_op != BIT_TEST) begin
      dmem_req.rd <= 1'b0;
      dmem_req.wr <= 1'b1;
      if (cur_reg.bit_op == BIT_SET) begin
        dmem_req.wdata <= dmem_rdata | (8'h01 << cur_reg.bit_num);
      end else begin
        dmem_req.wdata <= dmem_rdata & ~(8'h01 << cur_reg.bit_num);
      end
    end else begin
      dmem_req.rd <= 1'b0;
      dmem_req.wr <= 1'b0;
    end
  end

  // operand and accumulator results
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      operand <= 8'h00;
      operand_valid <= 1'b0;
      acc_load <= 1'b0;
      acc_out <= 8'h00;
      bit_result <= 1'b0;
      hold_reg <= 8'h00;
    end else begin
      operand_valid <= 1'b0;
      acc_load <= 1'b0;
      if (state_reg == ST_DATA) begin
        operand <= dmem_rdata;
        operand_valid <= 1'b1;
        if (cur_reg.mode == OP_BIT_OP) begin
          bit_result <= dmem_rdata[cur_reg.bit_num];
        end
      end else if (state_reg == ST_FETCH1) begin
        hold_reg <= pmem_rdata;
        if (cur_reg.mode == OP_IMM) begin
          operand <= pmem_rdata;
          operand_valid <= 1'b1;
        end else if (cur_reg.mode == OP_TABLE_LOAD) begin
          acc_out <= pmem_rdata;
          acc_load <= 1'b1;
        end
      end
    end
  end

  // program counter update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc <= PC_RST;
    end else if (state_reg == ST_DONE) begin
      case (cur_reg.mode)
        OP_REL_JUMP: pc <= rel_target;
        OP_ABS_JUMP: pc <= {pc[14:12], cur_reg.abs_target};
        OP_LONG_JUMP: pc <= cur_reg.long_target;
        OP_TABLE_JUMP: pc <= {pc[14:8], hold_reg};
        OP_VECTOR_JUMP: pc <= {hold_reg[6:0], pmem_rdata};
        OP_IMM: pc <= pc + 15'd2;
        default: pc <= pc_inc;
      endcase
    end
  end

  // data pointers and memory-mapped stack pointer; post step happens after the access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr0 <= PTR_RST;
      ptr1 <= PTR_RST;
      stack_ptr <= SP_RST;
    end else begin
      ptr0 <= ptr0_next;
      ptr1 <= ptr1_next;
      if (dmem_req.wr && dmem_req.addr == SP_ADDR) begin
        stack_ptr <= dmem_req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (state_reg == ST_IDLE) ? instr.valid : (state_reg != ST_DONE);
      done <= (state_reg == ST_DONE);
    end
  end
endmodule // operand_and_jump_addressing
`default_nettype wire

// ---- test/mem_model.sv ----
// program and data memory model facing the addressing block
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import addr_gen_pkg::*;
(
  input wire logic clk_sys,
  input wire logic pmem_rd,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire dmem_req_s dmem_req,
  output logic [7:0] pmem_rdata,
  output logic [7:0] dmem_rdata
);
  logic [PC_W-1:0] pa_q = '0;
  logic [7:0] da_q = 8'h00;
  logic [7:0] junk = 8'hA5;
  logic ph = 1'b0;
  logic dh = 1'b0;
  // answer in the read cycle, hold one more, then show a changing pattern
  always @(posedge clk_sys) begin
    if (pmem_rd) pa_q <= pmem_addr;
    if (dmem_req.rd) da_q <= dmem_req.addr;
    ph <= pmem_rd;
    dh <= dmem_req.rd;
    junk <= ~junk;
  end
  assign pmem_rdata = pmem_rd ? pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]} ^ 8'h5A :
    ph ? pa_q[7:0] ^ {1'b0, pa_q[14:8]} ^ 8'h5A : junk;
  assign dmem_rdata = dmem_req.rd ? dmem_req.addr ^ 8'hC3 : dh ? da_q ^ 8'hC3 : ~junk;
endmodule // mem_model
`default_nettype wire

// ---- test/operand_and_jump_addressing_checker.sv ----
// assertion checker for the addressing block
`timescale 1ns/1ps
`default_nettype none
module operand_and_jump_addressing_checker
  import addr_gen_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire instr_s instr,
  input wire logic [7:0] acc_in,
  input wire logic busy,
  input wire logic done,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic pmem_rd,
  input wire dmem_req_s dmem_req,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] ptr0,
  input wire logic [7:0] ptr1,
  input wire logic [7:0] stack_ptr
);
  instr_s q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] acc_q;
  logic [7:0] p0_q;
  logic [7:0] p1_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // snapshot taken at the accepting edge, held while busy
  always_ff @(posedge clk_sys) begin
    if (!busy) begin
      q <= instr;
      pc_q <= pc;
      acc_q <= acc_in;
      p0_q <= ptr0;
      p1_q <= ptr1;
    end
  end
  a_done_pulse: assert property (done |=> !done) else $error("done too long");
  a_busy_ends: assert property ($rose(busy) |-> ##[1:8] done) else $error("no done");
  a_direct_addr: assert property (dmem_req.rd && q.mode == OP_DIRECT
    |-> dmem_req.addr == q.addr_byte) else $error("direct addr wrong");
  a_ptr_addr: assert property (dmem_req.rd && q.mode inside {OP_IND, OP_IND_INC, OP_IND_DEC}
    |-> dmem_req.addr == (q.ptr_sel ? p1_q : p0_q)) else $error("pointer addr wrong");
  a_imm_fetch: assert property (pmem_rd && q.mode == OP_IMM
    |-> pmem_addr == pc_q + 15'h1) else $error("immediate addr wrong");
  a_table_addr: assert property (pmem_rd && q.mode inside {OP_TABLE_LOAD, OP_TABLE_JUMP}
    |-> pmem_addr == {pc_q[14:8], acc_q}) else $error("table addr wrong");
  a_short_load: assert property (done && q.mode == OP_IMM_SHORT
    |-> ptr0 == {4'h0, q.short_val}) else $error("short load wrong");
  a_ptr_step: assert property (done && q.mode inside {OP_IND_INC, OP_IND_DEC}
    |-> (q.ptr_sel ? ptr1 - p1_q : ptr0 - p0_q) == (q.mode == OP_IND_INC ? 8'h01 : 8'hFF))
    else $error("pointer step wrong");
  a_rel_jump: assert property (done && q.mode == OP_REL_JUMP
    |-> pc == pc_q + q.rel_disp - 15'h1F) else $error("relative jump wrong");
  a_abs_jump: assert property (done && q.mode == OP_ABS_JUMP
    |-> pc == {pc_q[14:12], q.abs_target}) else $error("absolute jump wrong");
  a_long_jump: assert property (done && q.mode == OP_LONG_JUMP
    |-> pc == q.long_target) else $error("long jump wrong");
  a_bit_read: assert property (dmem_req.rd && q.mode == OP_BIT_OP
    |-> dmem_req.addr == q.addr_byte) else $error("bit op addr wrong");
  a_bit_write: assert property (dmem_req.wr
    |-> q.mode == OP_BIT_OP && q.bit_op != BIT_TEST && dmem_req.addr == q.addr_byte)
    else $error("unexpected data write");
  a_stack_load: assert property (dmem_req.wr && dmem_req.addr == SP_ADDR
    |=> stack_ptr == $past(dmem_req.wdata)) else $error("stack pointer not loaded");
endmodule // operand_and_jump_addressing_checker
bind operand_and_jump_addressing operand_and_jump_addressing_checker u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .instr(instr),
  .acc_in(acc_in),
  .busy(busy),
  .done(done),
  .pmem_addr(pmem_addr),
  .pmem_rd(pmem_rd),
  .dmem_req(dmem_req),
  .pc(pc),
  .ptr0(ptr0),
  .ptr1(ptr1),
  .stack_ptr(stack_ptr)
);
`default_nettype wire

// ---- test/operand_and_jump_addressing_bench.sv ----
// self-checking bench for the addressing block
`timescale 1ns/1ps
`default_nettype none
module operand_and_jump_addressing_bench;
  import addr_gen_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  instr_s instr = '0;
  instr_s i;
  logic [7:0] acc_in = 8'h00, pmem_rdata, dmem_rdata, operand, acc_out, got_op, got_acc;
  logic busy, done, pmem_rd, operand_valid, acc_load, bit_result;
  logic [PC_W-1:0] pmem_addr, pc;
  logic [7:0] ptr0, ptr1, stack_ptr, a;
  dmem_req_s dmem_req;
  int n_errors = 0, comparisons = 0, e_pc = 0, e_p0 = 0, e_p1 = 0, n, eo, ea, t, k;
  int ec, eb, ew, nw, e_sp, n_wr = 0;
  logic [7:0] got_wr;
  always #12.5 clk_sys = ~clk_sys;
  operand_and_jump_addressing u_operand_and_jump_addressing (
    .clk_sys(clk_sys),
    .rst(rst),
    .instr(instr),
    .acc_in(acc_in),
    .pmem_rdata(pmem_rdata),
    .dmem_rdata(dmem_rdata),
    .busy(busy),
    .done(done),
    .pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd),
    .dmem_req(dmem_req),
    .operand(operand),
    .operand_valid(operand_valid),
    .acc_load(acc_load),
    .acc_out(acc_out),
    .bit_result(bit_result),
    .pc(pc),
    .ptr0(ptr0),
    .ptr1(ptr1),
    .stack_ptr(stack_ptr)
  );
  mem_model u_mem_model (
    .clk_sys(clk_sys),
    .pmem_rd(pmem_rd),
    .pmem_addr(pmem_addr),
    .dmem_req(dmem_req),
    .pmem_rdata(pmem_rdata),
    .dmem_rdata(dmem_rdata)
  );
  always @(posedge clk_sys) begin
    if (operand_valid) got_op <= operand;
    if (acc_load) got_acc <= acc_out;
    if (dmem_req.wr) begin
      n_wr <= n_wr + 1;
      got_wr <= dmem_req.wdata;
    end
  end
  function automatic int pb(int x);
    return (x ^ ((x & 'h7FFF) >> 8) ^ 'h5A) & 'hFF;
  endfunction
  task automatic chk(logic [14:0] g, logic [14:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h2562));
    e_sp = SP_RST;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    chk(pc, PC_RST);
    chk(15'(stack_ptr), 15'(SP_RST));
    for (t = 0; t < 90; t++) begin
      i = instr_s'(71'({$urandom, $urandom, $urandom}));
      i.mode = op_mode_e'(4'($urandom_range(1, 13)));
      // every mode but OP_NONE is visited once before the random mix
      if (t < 13) i.mode = op_mode_e'(4'(t + 1));
      i.bit_op = bit_op_e'(2'($urandom_range(0, 2)));
      if (i.mode == OP_BIT_OP && t % 4 == 0) i.addr_byte = SP_ADDR;
      if (i.rel_disp == 6'd32) i.rel_disp = 6'd33;
      if (i.mode == OP_IMM_SHORT) i.ptr_sel = 1'b0;
      a = 8'($urandom);
      eo = (i.ptr_sel ? e_p1 : e_p0) ^ 'hC3;
      if (!(i.mode inside {OP_IND, OP_IND_INC, OP_IND_DEC})) eo = -1;
      k = (i.mode == OP_IND_INC) ? 1 : (i.mode == OP_IND_DEC) ? 255 : 0;
      if (i.ptr_sel) e_p1 = (e_p1 + k) % 256;
      else e_p0 = (e_p0 + k) % 256;
      ea = -1;
      n = e_pc + 1;
      case (i.mode)
        OP_DIRECT, OP_BIT_OP: eo = i.addr_byte ^ 'hC3;
        OP_IMM: eo = pb(e_pc + 1);
        OP_IMM_SHORT: e_p0 = i.short_val;
        OP_TABLE_LOAD: ea = pb((e_pc & 'h7F00) | a);
        OP_REL_JUMP: n = e_pc + i.rel_disp - 31;
        OP_ABS_JUMP: n = (e_pc & 'h7000) | i.abs_target;
        OP_LONG_JUMP: n = i.long_target;
        OP_TABLE_JUMP: n = (e_pc & 'h7F00) | pb((e_pc & 'h7F00) | a);
        OP_VECTOR_JUMP: n = ((pb(i.vector_addr) & 'h7F) << 8) | pb(i.vector_addr + 1);
        default: ;
      endcase
      if (i.mode == OP_IMM) n = e_pc + 2;
      ec = (i.mode inside {OP_REL_JUMP, OP_ABS_JUMP, OP_LONG_JUMP, OP_IMM_SHORT}) ? 1 : 2;
      nw = (i.mode == OP_BIT_OP && i.bit_op != BIT_TEST) ? 1 : 0;
      if (i.mode == OP_VECTOR_JUMP || nw == 1) ec = 3;
      eb = ((i.addr_byte ^ 'hC3) >> i.bit_num) & 1;
      if (i.bit_op == BIT_SET) ew = (i.addr_byte ^ 'hC3) | (1 << i.bit_num);
      else ew = (i.addr_byte ^ 'hC3) & ~(1 << i.bit_num) & 'hFF;
      if (nw == 1 && i.addr_byte == SP_ADDR) e_sp = ew;
      e_pc = n & 'h7FFF;
      got_op = 'x;
      got_acc = 'x;
      n_wr = 0;
      @(negedge clk_sys);
      i.valid = 1'b1;
      instr = i;
      acc_in = a;
      @(negedge clk_sys);
      instr.valid = 1'b0;
      chk(15'(busy), 15'h1);
      for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge clk_sys);
      chk(15'(done), 15'h1);
      chk(pc, 15'(e_pc));
      chk(15'(ptr0), 15'(e_p0));
      chk(15'(ptr1), 15'(e_p1));
      if (eo >= 0) chk(15'(got_op), 15'(eo));
      if (ea >= 0) chk(15'(got_acc), 15'(ea));
      chk(15'(k), 15'(ec));
      chk(15'(busy), 15'h0);
      chk(15'(n_wr), 15'(nw));
      chk(15'(stack_ptr), 15'(e_sp));
      if (i.mode == OP_BIT_OP) chk(15'(bit_result), 15'(eb));
      if (nw == 1) chk(15'(got_wr), 15'(ew));
    end
    end_sim();
  end
endmodule // operand_and_jump_addressing_bench
`default_nettype wire
